//--- design/tbdf_time_base.sv
`timescale 1ns/1ps
`include "tbdf_cfg.svh"

// Summary of operation
// - system tick is external clock over 4x divider, or a fixed 4000 ns tick when internal
// - divider integer resets to four, host writable
// - twelve-bit values: high byte, then nibble plus zeros
// - power values split into three bytes, msb first
// - accumulators are four bytes, msb first
// - count lasts N ticks of chosen time base
// - N selected by control A select fields

module tbdf_time_base (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ext_clock_input,
  input wire tbdf_pkg::tbdf_src_t clock_source,
  input wire logic [1:0] ctrl_a_upper_select,
  input wire logic [2:0] ctrl_a_lower_select,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic sys_tick,
  output logic [31:0] time_count,
  output logic time_wrap,
  input wire tbdf_pkg::tbdf_fmt_kind_t fmt_kind,
  input wire logic [1:0] fmt_lane,
  input wire logic [31:0] fmt_value,
  output tbdf_pkg::tbdf_byte_t fmt_byte,
  input wire logic [1:0] time_lane,
  output tbdf_pkg::tbdf_byte_t time_byte
);
  import tbdf_pkg::*;

  // ---------------------------------------------------------------
  // time-per-count factor lookup
  // ---------------------------------------------------------------
  function automatic logic [26:0] n_scaled(input logic [1:0] up, input logic [2:0] lo);
    logic [26:0] n;
    n = `TBDF_N_X110;
    // 111 is not a listed code; it behaves like 110
    if (lo == 3'b110 || lo == 3'b111) begin
      n = `TBDF_N_X110;
    end else begin
      case (up)
        2'b11: begin
          case (lo)
            3'b011: n = `TBDF_N_11_011;
            3'b010, 3'b101: n = `TBDF_N_11_010;
            3'b001, 3'b100: n = `TBDF_N_11_001;
            default: n = `TBDF_N_11_000;
          endcase
        end
        2'b10: begin
          case (lo)
            3'b011: n = `TBDF_N_10_011;
            3'b010, 3'b101: n = `TBDF_N_10_010;
            3'b001, 3'b100: n = `TBDF_N_10_001;
            default: n = `TBDF_N_10_000;
          endcase
        end
        2'b01: begin
          case (lo)
            3'b011: n = `TBDF_N_01_011;
            3'b010, 3'b101: n = `TBDF_N_01_010;
            3'b001, 3'b100: n = `TBDF_N_01_001;
            default: n = `TBDF_N_01_000;
          endcase
        end
        default: begin
          case (lo)
            3'b011: n = `TBDF_N_00_011;
            3'b010, 3'b101: n = `TBDF_N_00_010;
            3'b001, 3'b100: n = `TBDF_N_00_001;
            default: n = `TBDF_N_00_000;
          endcase
        end
      endcase
    end
    return n;
  endfunction

  // ---------------------------------------------------------------
  // divider register
  // ---------------------------------------------------------------
  localparam logic [7:0] CLK_DIV_RESET = `TBDF_CLK_DIV_RESET;
  logic [4:0] divider_integer;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      divider_integer <= CLK_DIV_RESET[`TBDF_DIV_MSB:`TBDF_DIV_LSB];
    end else if (reg_wr && reg_addr == `TBDF_CLK_DIV_ADDR) begin
      // upper bits of the write are dropped
      divider_integer <= reg_wdata[`TBDF_DIV_MSB:`TBDF_DIV_LSB];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (reg_addr == `TBDF_CLK_DIV_ADDR) begin
          reg_rdata <= {3'b000, divider_integer};
        end else begin
          reg_rdata <= `TBDF_UNMAPPED_DATA;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // external clock pin synchroniser and edge detect
  // ---------------------------------------------------------------
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic ext_rise;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_clock_input;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // pin must run below half of clk_sys or edges are missed
  assign ext_rise = ext_sync && !ext_prev;

  // ---------------------------------------------------------------
  // system tick divider
  // ---------------------------------------------------------------
  localparam logic [8:0] INT_TICK_LAST = 9'(`TBDF_INT_TICK_CYCLES - 1);
  localparam logic [6:0] EDGES_PER_UNIT = 7'(`TBDF_EDGES_PER_UNIT);

  logic [6:0] edge_count;
  logic [6:0] edge_last;
  logic [8:0] int_count;
  logic [4:0] div_eff;
  tbdf_src_t src_prev;
  logic src_change;

  // a zero divider would never tick; it runs as one
  assign div_eff = (divider_integer == 5'd0) ? 5'd1 : divider_integer;
  assign edge_last = 7'(EDGES_PER_UNIT * {2'b00, div_eff} - 7'd1);
  assign src_change = (clock_source != src_prev);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      src_prev <= TBDF_SRC_INTERNAL;
    end else begin
      src_prev <= clock_source;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || src_change) begin
      edge_count <= 7'd0;
    end else if (clock_source == TBDF_SRC_EXTERNAL && ext_rise) begin
      // a lowered divider restarts the count at the next pin rising edge
      if (edge_count >= edge_last) begin
        edge_count <= 7'd0;
      end else begin
        edge_count <= edge_count + 7'd1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || src_change) begin
      int_count <= 9'd0;
    end else if (clock_source == TBDF_SRC_INTERNAL) begin
      if (int_count == INT_TICK_LAST) begin
        int_count <= 9'd0;
      end else begin
        int_count <= int_count + 9'd1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || src_change) begin
      sys_tick <= 1'b0;
    end else if (clock_source == TBDF_SRC_EXTERNAL) begin
      sys_tick <= ext_rise && (edge_count >= edge_last);
    end else begin
      sys_tick <= (int_count == INT_TICK_LAST);
    end
  end

  // ---------------------------------------------------------------
  // time counter with fractional factor
  // ---------------------------------------------------------------
  logic [26:0] n_now;
  logic [26:0] frac_acc;
  logic [26:0] frac_sum;
  logic count_step;

  assign n_now = n_scaled(ctrl_a_upper_select, ctrl_a_lower_select);
  assign frac_sum = frac_acc + `TBDF_N_SCALE;
  assign count_step = sys_tick && (frac_sum >= n_now);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frac_acc <= 27'd0;
    end else if (sys_tick) begin
      if (frac_sum >= n_now) begin
        frac_acc <= frac_sum - n_now;
      end else begin
        frac_acc <= frac_sum;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      time_count <= 32'h0000_0000;
    end else if (count_step) begin
      time_count <= time_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      time_wrap <= 1'b0;
    end else begin
      time_wrap <= count_step && (time_count == 32'hffff_ffff);
    end
  end

  // ---------------------------------------------------------------
  // byte formatting
  // ---------------------------------------------------------------
  tbdf_byte_fmt u_fmt_meas (
    .clk_sys(clk_sys),
    .reset(reset),
    .kind(fmt_kind),
    .lane(fmt_lane),
    .value(fmt_value),
    .data_byte(fmt_byte)
  );

  tbdf_byte_fmt u_fmt_time (
    .clk_sys(clk_sys),
    .reset(reset),
    .kind(TBDF_FMT_ACC32),
    .lane(time_lane),
    .value(time_count),
    .data_byte(time_byte)
  );

endmodule

//--- design/tbdf_cfg.svh
`ifndef TBDF_CFG_SVH
`define TBDF_CFG_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define TBDF_CLK_DIV_ADDR 8'h43
`define TBDF_CLK_DIV_RESET 8'h04
`define TBDF_DIV_LSB 0
`define TBDF_DIV_MSB 4
`define TBDF_UNMAPPED_DATA 8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TBDF_CLK_SYS_NS 10
`define TBDF_INT_TICK_NS 4000
`define TBDF_INT_TICK_CYCLES (`TBDF_INT_TICK_NS / `TBDF_CLK_SYS_NS)
`define TBDF_EDGES_PER_UNIT 4

// ---------------------------------------------------------------
// time per count factor, scaled by ten thousand
// ---------------------------------------------------------------
`define TBDF_N_SCALE 27'd10000
`define TBDF_N_X110 27'd40985000
`define TBDF_N_11_011 27'd40997500
`define TBDF_N_11_010 27'd40985098
`define TBDF_N_11_001 27'd40985806
`define TBDF_N_11_000 27'd40993333
`define TBDF_N_10_011 27'd40997355
`define TBDF_N_10_010 27'd40985097
`define TBDF_N_10_001 27'd40985800
`define TBDF_N_10_000 27'd40993549
`define TBDF_N_01_011 27'd40996429
`define TBDF_N_01_010 27'd40985092
`define TBDF_N_01_001 27'd40985758
`define TBDF_N_01_000 27'd40992692
`define TBDF_N_00_011 27'd40990000
`define TBDF_N_00_010 27'd40985049
`define TBDF_N_00_001 27'd40985397
`define TBDF_N_00_000 27'd40988571

`endif

//--- design/tbdf_pkg.sv
package tbdf_pkg;

  typedef logic [7:0] tbdf_byte_t;

  typedef enum logic [1:0] {
    TBDF_FMT_ADC12,
    TBDF_FMT_PWR24,
    TBDF_FMT_ACC32
  } tbdf_fmt_kind_t;

  typedef enum logic {
    TBDF_SRC_INTERNAL,
    TBDF_SRC_EXTERNAL
  } tbdf_src_t;

endpackage

//--- design/tbdf_byte_fmt.sv
`timescale 1ns/1ps

module tbdf_byte_fmt (
  input wire logic clk_sys,
  input wire logic reset,
  input wire tbdf_pkg::tbdf_fmt_kind_t kind,
  input wire logic [1:0] lane,
  input wire logic [31:0] value,
  output tbdf_pkg::tbdf_byte_t data_byte
);
  import tbdf_pkg::*;

  // ---------------------------------------------------------------
  // lane selection, lane 0 is the most significant byte
  // ---------------------------------------------------------------
  tbdf_byte_t lanes_acc [4];
  tbdf_byte_t next_byte;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lanes_acc[g] = value[31 - 8 * g -: 8];
    end
  endgenerate

  always_comb begin
    next_byte = 8'h00;
    case (kind)
      TBDF_FMT_ADC12: begin
        case (lane)
          2'd0: next_byte = value[11:4];
          2'd1: next_byte = {value[3:0], 4'h0};
          default: next_byte = 8'h00;
        endcase
      end
      TBDF_FMT_PWR24: begin
        case (lane)
          2'd0: next_byte = value[23:16];
          2'd1: next_byte = value[15:8];
          2'd2: next_byte = value[7:0];
          default: next_byte = 8'h00;
        endcase
      end
      TBDF_FMT_ACC32: next_byte = lanes_acc[lane];
      default: next_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_byte <= 8'h00;
    end else begin
      data_byte <= next_byte;
    end
  end

endmodule

//--- verification/tbdf_time_base_sva.sv
`timescale 1ns/1ps

module tbdf_time_base_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire tbdf_pkg::tbdf_src_t clock_source,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sys_tick,
  input wire logic [31:0] time_count,
  input wire logic time_wrap,
  input wire tbdf_pkg::tbdf_fmt_kind_t fmt_kind,
  input wire logic [1:0] fmt_lane,
  input wire logic [31:0] fmt_value,
  input wire tbdf_pkg::tbdf_byte_t fmt_byte,
  input wire logic [1:0] time_lane,
  input wire tbdf_pkg::tbdf_byte_t time_byte
);
  import tbdf_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ------------------------------------------------
  // tick spacing helper
  // ------------------------------------------------
  logic [15:0] gap;
  logic seen;
  always_ff @(posedge clk_sys) begin
    if (reset || $changed(clock_source)) begin
      gap <= 16'h0000;
      seen <= 1'b0;
    end else begin
      gap <= sys_tick ? 16'h0001 : gap + 16'h0001;
      seen <= seen | sys_tick;
    end
  end
  AST_RVALID: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe without valid");
  AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
    else $error("valid without read strobe");
  AST_RSV_ZERO: assert property (reg_rvalid |-> reg_rdata[7:5] == 3'h0)
    else $error("reserved divider bits not zero");
  AST_TICK_PULSE: assert property (sys_tick |=> !sys_tick)
    else $error("tick wider than one cycle");
  AST_INT_TICK: assert property ((sys_tick && seen && clock_source == TBDF_SRC_INTERNAL)
    |-> gap == 16'd400) else $error("internal tick spacing wrong");
  AST_COUNT_HOLD: assert property ((!sys_tick && $stable(clock_source))
    |=> $stable(time_count)) else $error("count moved without tick");
  AST_COUNT_STEP: assert property ($changed(time_count)
    |-> (time_count == $past(time_count) + 32'h1) || (time_count == 32'h0))
    else $error("count step not one");
  AST_FMT_ADC: assert property ((fmt_kind == TBDF_FMT_ADC12 && fmt_lane == 2'd1)
    |=> fmt_byte == {$past(fmt_value[3:0]), 4'h0}) else $error("adc low byte wrong");
  AST_FMT_PWR: assert property ((fmt_kind == TBDF_FMT_PWR24 && fmt_lane == 2'd3)
    |=> fmt_byte == 8'h00) else $error("power spare lane not zero");
  AST_FMT_ACC: assert property (fmt_kind == TBDF_FMT_ACC32 |=> fmt_byte ==
    8'(($past(fmt_value) >> (8 * (3 - $past(fmt_lane)))))) else $error("acc byte wrong");
  AST_TIME_BYTE: assert property ($stable(time_count) [*2] |-> time_byte ==
    8'(($past(time_count) >> (8 * (3 - $past(time_lane)))))) else $error("time byte wrong");
  // wrap pulse only follows an all-ones count
  AST_NO_WRAP: assert property ((time_count != 32'hffff_ffff) |=> !time_wrap)
    else $error("wrap pulse without full count");
endmodule

bind tbdf_time_base tbdf_time_base_sva i_tbdf_time_base_sva (
  .clk_sys(clk_sys),
  .reset(reset),
  .clock_source(clock_source),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .sys_tick(sys_tick),
  .time_count(time_count),
  .time_wrap(time_wrap),
  .fmt_kind(fmt_kind),
  .fmt_lane(fmt_lane),
  .fmt_value(fmt_value),
  .fmt_byte(fmt_byte),
  .time_lane(time_lane),
  .time_byte(time_byte)
);

//--- verification/tbdf_ext_clk_src.sv
`timescale 1ns/1ps

// pin stands low outside runs; 40 ns period stays under the edge detect limit
module tbdf_ext_clk_src #(parameter int HALF_NS = 20) (
  input wire logic run,
  output logic ext_clock_input
);
  initial begin
    ext_clock_input = 1'b0;
    #3;
    forever begin
      #HALF_NS;
      ext_clock_input = run ? ~ext_clock_input : 1'b0;
    end
  end
endmodule

//--- verification/time_base_and_data_format_tb.sv
`timescale 1ns/1ps

module time_base_and_data_format_tb;
  import tbdf_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, run = 1'b0, ext_clock_input;
  tbdf_src_t clock_source = TBDF_SRC_INTERNAL;
  logic [1:0] upr = 2'h0, fmt_lane = 2'h0, time_lane = 2'h0;
  logic [2:0] lwr = 3'h3;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, sys_tick, time_wrap;
  logic [31:0] time_count, fmt_value = 32'h0;
  tbdf_fmt_kind_t fmt_kind = TBDF_FMT_ADC12;
  tbdf_byte_t fmt_byte, time_byte;
  int n_fail = 0, n_checks = 0, seed = 32'h95ce, div = 4, g, k, i;
  always #5 clk_sys = ~clk_sys;
  tbdf_ext_clk_src i_tbdf_ext_clk_src (.run(run), .ext_clock_input(ext_clock_input));
  tbdf_time_base i_tbdf_time_base (.clk_sys(clk_sys), .reset(reset),
    .ext_clock_input(ext_clock_input), .clock_source(clock_source),
    .ctrl_a_upper_select(upr), .ctrl_a_lower_select(lwr), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sys_tick(sys_tick), .time_count(time_count),
    .time_wrap(time_wrap), .fmt_kind(fmt_kind), .fmt_lane(fmt_lane),
    .fmt_value(fmt_value), .fmt_byte(fmt_byte), .time_lane(time_lane),
    .time_byte(time_byte));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == 8'h43) div = d & 8'h1f;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    chk(reg_rdata, (a == 8'h43) ? div : 0);
  endtask
  // ------------------------------------------------
  // bounded wait: cycles from one tick to the next
  // ------------------------------------------------
  task automatic tick_gap(output int c);
    c = 0;
    for (int j = 0; j < 2; j++) begin
      k = 0;
      do begin
        @(posedge clk_sys);
        #1;
        k++;
      end while (sys_tick !== 1'b1 && k < 2000);
      if (k >= 2000) begin
        n_fail++;
        results();
      end
      c = k;
    end
  endtask
  function automatic int fmt_model(int kd, int ln, logic [31:0] v);
    if (kd == 0) return (ln == 0) ? v[11:4] : (ln == 1) ? {v[3:0], 4'h0} : 0;
    if (kd == 1) return (ln == 3) ? 0 : (v >> (8 * (2 - ln))) & 8'hff;
    if (kd == 2) return (v >> (8 * (3 - ln))) & 8'hff;
    return 0;
  endfunction
  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h43);
    wr(8'h43, 8'hff);
    rd(8'h43);
    rd(8'h42);
    for (i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      fmt_kind <= tbdf_fmt_kind_t'(i % 3);
      fmt_lane <= 2'(i / 3);
      time_lane <= 2'(i);
      fmt_value <= $random(seed);
      @(posedge clk_sys);
      #1;
      chk(fmt_byte, fmt_model(fmt_kind, fmt_lane, fmt_value));
    end
    tick_gap(g);
    chk(g, 400);
    @(posedge clk_sys);
    clock_source <= TBDF_SRC_EXTERNAL;
    run <= 1'b1;
    for (i = 1; i < 3; i++) begin
      wr(8'h43, 8'(i));
      tick_gap(g);
      tick_gap(g);
      chk(g, 16 * i);
    end
    // second reset restarts the count from zero
    @(posedge clk_sys);
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    div = 4;
    rd(8'h43);
    wr(8'h43, 8'h01);
    g = 0;
    for (k = 0; k < 80000 && time_count !== 32'h1; k++) begin
      @(posedge clk_sys);
      #1;
      if (sys_tick === 1'b1) g++;
    end
    chk(g, 4099);
    // a run-out bound leaves the count short and fails here
    chk(time_count, 32'h1);
    @(posedge clk_sys);
    time_lane <= 2'd3;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(time_byte, 8'h01);
    chk(time_wrap, 1'b0);
    results();
  end
endmodule
